/* design/rtcp_core.sv */
// Real-time counter with calibration, sync latency and periodic tick
//
// Summary of operation
// - With keep_running_in_halt clear the counter freezes and ignores ticks while the CPU is halted, otherwise it keeps counting.
// - Calibration sign 0 slows the prescaler by dropping ticks, sign 1 speeds it by adding ticks.
// - The seven-bit magnitude is the number of ticks added or dropped per million timekeeping ticks.
// - The source field picks internal 32k, its 1k tap, the 32k crystal or the external pin.
// - The 16-bit tick_value reads as low byte at 0x08 and high byte at 0x09 and resets to zero.
// - A tick_value write lands two timekeeping ticks later with tick_sync_pending set meanwhile.
// - The wrap limit sits as low byte at 0x0a and high byte at 0x0b and resets to all ones.
// - A wrap limit write lands two timekeeping ticks later with limit_sync_pending set meanwhile.
// - The match value sits as low byte at 0x0c and high byte at 0x0d and resets to zero.
// - A match value write lands two timekeeping ticks later with match_sync_pending set meanwhile.
// - Periodic code 0 gives no tick, codes 1 to 14 give 4 up to 32768 ticks, code 15 gives none.
// - Frequency correction acts only while correction_enable is set.
// - Reaching the wrap limit wraps to zero and sets wrap_flag, cleared by reading the flags or by writing one.
// - The counter equalling the match value sets the match flag, cleared by reading the flags or by writing one.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rtcp_core #(
    parameter int unsigned PPM_INTERVAL = rtcp_pkg::PPM_INTERVAL,
    parameter int unsigned TAP_DIV = rtcp_pkg::TAP_DIV
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic internal_32k_oscillator_in,
    input wire logic crystal_32k_source_in,
    input wire logic external_pin_source_in,
    input wire logic cpu_halted_in,
    output logic irq_out
);
    localparam int TW = $clog2(TAP_DIV);
    localparam int PW = $clog2(PPM_INTERVAL);
    localparam logic [PW-1:0] PPM_LAST = PW'(PPM_INTERVAL - 1);

    if (TAP_DIV < 2 || (TAP_DIV & (TAP_DIV - 1)) != 0) begin : g_tap_chk
        $error("TAP_DIV must be a power of two");
    end
    if (PPM_INTERVAL < 2) begin : g_ppm_chk
        $error("PPM_INTERVAL too small");
    end

    function automatic logic [15:0] ones(input logic [4:0] n);
        ones = 16'((17'h1 << n) - 17'h1);
    endfunction : ones

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rtcp_pkg::rtcp_bus_t bus_reg, bus_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] ctrl_reg, ctrl_next, dbg_reg, dbg_next;
    logic [7:0] frequency_calibration_reg, frequency_calibration_next, sel_reg, sel_next;
    logic [7:0] pit_reg, pit_next;
    logic [2:0] mask_reg, mask_next, flags_reg, flags_next;
    logic [15:0] cnt_reg, cnt_next, per_reg, per_next;
    logic [15:0] cmp_reg, cmp_next;
    logic [15:0] stage_reg [3];
    logic [15:0] stage_next [3];
    logic [1:0] pend_reg [3];
    logic [1:0] pend_next [3];
    logic [TW-1:0] tap_reg, tap_next;
    logic osc_prev_reg, osc_prev_next, src_prev_reg, src_prev_next;
    logic [16:0] pre_reg, pre_next;
    logic [PW-1:0] ppm_reg, ppm_next;
    logic [6:0] corr_reg, corr_next;
    logic [14:0] pitc_reg, pitc_next;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic src, tick, go, en, wr, rd, ptick;
        logic [2:0] wr_sy, setf, clrf;
        logic [1:0] inc;
        logic [16:0] div, sum;
        logic [15:0] pm, cn;
        logic [3:0] code;
        logic [7:0] wb, rv;
        src = 1'b0;
        tick = 1'b0;
        go = 1'b0;
        en = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        ptick = 1'b0;
        wr_sy = 3'h0;
        setf = 3'h0;
        clrf = 3'h0;
        inc = 2'h1;
        div = 17'h0;
        sum = 17'h0;
        pm = 16'h0;
        cn = 16'h0;
        code = pit_reg[rtcp_pkg::PIT_CODE_LSB +: 4];
        wb = avs_writedata_in[7:0];
        rv = 8'h00;
        bus_next = bus_reg;
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        dbg_next = dbg_reg;
        frequency_calibration_next = frequency_calibration_reg;
        sel_next = sel_reg;
        pit_next = pit_reg;
        mask_next = mask_reg;
        cnt_next = cnt_reg;
        per_next = per_reg;
        cmp_next = cmp_reg;
        stage_next = stage_reg;
        pend_next = pend_reg;
        tap_next = tap_reg;
        ppm_next = ppm_reg;
        corr_next = corr_reg;
        pre_next = pre_reg;
        pitc_next = pitc_reg;
        // Bus: one wait state so read data comes from a flop
        wr = bus_reg == rtcp_pkg::BUS_ACK && avs_write_in
            && avs_byteenable_in[0];
        rd = bus_reg == rtcp_pkg::BUS_ACK && avs_read_in;
        case (bus_reg)
            rtcp_pkg::BUS_IDLE: begin
                if (avs_read_in || avs_write_in)
                    bus_next = rtcp_pkg::BUS_ACK;
            end
            rtcp_pkg::BUS_ACK: bus_next = rtcp_pkg::BUS_IDLE;
            default: bus_next = rtcp_pkg::BUS_IDLE;
        endcase
        case (avs_address_in)
            rtcp_pkg::IDX_CTRL: rv = ctrl_reg;
            rtcp_pkg::IDX_STATUS: rv = {4'h0, pend_reg[2] != 2'h0,
                pend_reg[1] != 2'h0, pend_reg[0] != 2'h0, 1'b0};
            rtcp_pkg::IDX_INTMASK: rv = {5'h00, mask_reg};
            rtcp_pkg::IDX_INTFLAGS: rv = {5'h00, flags_reg};
            rtcp_pkg::IDX_DBG: rv = dbg_reg;
            rtcp_pkg::IDX_FREQUENCY_CALIBRATION: rv = frequency_calibration_reg;
            rtcp_pkg::IDX_CLOCK_SOURCE_SELECT: rv = sel_reg;
            rtcp_pkg::IDX_CNT_L: rv = cnt_reg[7:0];
            rtcp_pkg::IDX_CNT_H: rv = cnt_reg[15:8];
            rtcp_pkg::IDX_PER_L: rv = stage_reg[1][7:0];
            rtcp_pkg::IDX_PER_H: rv = stage_reg[1][15:8];
            rtcp_pkg::IDX_CMP_L: rv = stage_reg[2][7:0];
            rtcp_pkg::IDX_CMP_H: rv = stage_reg[2][15:8];
            rtcp_pkg::IDX_PIT: rv = pit_reg;
            default: rv = 8'h00;
        endcase
        if (bus_reg == rtcp_pkg::BUS_IDLE && avs_read_in)
            rdata_next = {24'h000000, rv};
        if (wr) begin
            case (avs_address_in)
                rtcp_pkg::IDX_CTRL: ctrl_next = wb;
                rtcp_pkg::IDX_INTMASK: mask_next = wb[2:0];
                rtcp_pkg::IDX_INTFLAGS: clrf = wb[2:0];
                rtcp_pkg::IDX_DBG: dbg_next = {7'h00, wb[0]};
                rtcp_pkg::IDX_FREQUENCY_CALIBRATION: frequency_calibration_next = wb;
                rtcp_pkg::IDX_CLOCK_SOURCE_SELECT: sel_next = {6'h00, wb[1:0]};
                rtcp_pkg::IDX_CNT_L, rtcp_pkg::IDX_CNT_H,
                rtcp_pkg::IDX_PER_L, rtcp_pkg::IDX_PER_H,
                rtcp_pkg::IDX_CMP_L, rtcp_pkg::IDX_CMP_H: begin
                    for (int i = 0; i < 3; i++) begin
                        if (avs_address_in[2:1] == 2'(i)) begin
                            wr_sy[i] = 1'b1;
                            if (avs_address_in[0])
                                stage_next[i][15:8] = wb;
                            else
                                stage_next[i][7:0] = wb;
                        end
                    end
                end
                rtcp_pkg::IDX_PIT: pit_next = {1'b0, wb[6:3], 2'h0, wb[0]};
                default: ;
            endcase
        end
        if (rd && avs_address_in == rtcp_pkg::IDX_INTFLAGS)
            clrf = 3'h7;
        // Timekeeping clock: sampled source, rising edge is one tick
        osc_prev_next = internal_32k_oscillator_in;
        if (internal_32k_oscillator_in && !osc_prev_reg)
            tap_next = TW'(tap_reg + 1'b1);
        case (sel_reg[1:0])
            rtcp_pkg::SRC_INT32K: src = internal_32k_oscillator_in;
            rtcp_pkg::SRC_INT1K: src = tap_reg[TW-1];
            rtcp_pkg::SRC_XTAL: src = crystal_32k_source_in;
            rtcp_pkg::SRC_EXT: src = external_pin_source_in;
            default: src = 1'b0;
        endcase
        src_prev_next = src;
        tick = src && !src_prev_reg;
        go = tick && !(cpu_halted_in && !dbg_reg[0]);
        en = ctrl_reg[rtcp_pkg::CTRL_EN_BIT];
        // Crossing latency: value lands on the second tick
        for (int i = 0; i < 3; i++) begin
            if (wr_sy[i])
                pend_next[i] = rtcp_pkg::SYNC_LAT;
            else if (tick && pend_reg[i] != 2'h0)
                pend_next[i] = pend_reg[i] - 2'h1;
        end
        if (tick && pend_reg[rtcp_pkg::SY_PER] == 2'h1 && !wr_sy[1])
            per_next = stage_reg[rtcp_pkg::SY_PER];
        if (tick && pend_reg[rtcp_pkg::SY_CMP] == 2'h1 && !wr_sy[2])
            cmp_next = stage_reg[rtcp_pkg::SY_CMP];
        // Calibration: corrections front-loaded in each interval
        if (go && en) begin
            if (ppm_reg == PPM_LAST) begin
                ppm_next = '0;
                corr_next = frequency_calibration_reg[6:0];
            end else begin
                ppm_next = ppm_reg + 1'b1;
            end
            if (ctrl_reg[rtcp_pkg::CTRL_CORR_BIT] && corr_reg != 7'h00)
            begin
                inc = frequency_calibration_reg[rtcp_pkg::FREQUENCY_CALIBRATION_SIGN_BIT] ? 2'h2 : 2'h0;
                corr_next = corr_reg - 7'h01;
            end
            // Speed-up correction (sign 1) assumes divide by two or more
            div = 17'h1 << ctrl_reg[rtcp_pkg::CTRL_PRE_LSB +: 4];
            sum = pre_reg + 17'(inc);
            if (sum >= div) begin
                ptick = 1'b1;
                pre_next = sum - div;
            end else begin
                pre_next = sum;
            end
        end
        if (tick && pend_reg[rtcp_pkg::SY_CNT] == 2'h1 && !wr_sy[0]) begin
            cnt_next = stage_reg[rtcp_pkg::SY_CNT];
        end else if (ptick) begin
            if (cnt_reg == per_reg) begin
                cn = 16'h0000;
                setf[rtcp_pkg::FLAG_WRAP] = 1'b1;
            end else begin
                cn = cnt_reg + 16'h0001;
            end
            cnt_next = cn;
            if (cn == cmp_reg)
                setf[rtcp_pkg::FLAG_MATCH] = 1'b1;
        end
        // Periodic tick from raw timekeeping ticks
        if (go && pit_reg[rtcp_pkg::PIT_EN_BIT]) begin
            pitc_next = pitc_reg + 15'h0001;
            pm = ones(5'(code) + 5'h01);
            if (code != rtcp_pkg::PIT_OFF && code != rtcp_pkg::PIT_RSVD
                && ({1'b0, pitc_reg} & pm) == pm)
                setf[rtcp_pkg::FLAG_PIT] = 1'b1;
        end
        // Set beats a clear in the same cycle
        flags_next = (flags_reg & ~clrf) | setf;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_reg <= rtcp_pkg::BUS_IDLE;
            rdata_reg <= 32'h00000000;
            ctrl_reg <= rtcp_pkg::RST_BYTE;
            dbg_reg <= rtcp_pkg::RST_BYTE;
            frequency_calibration_reg <= rtcp_pkg::RST_BYTE;
            sel_reg <= rtcp_pkg::RST_BYTE;
            pit_reg <= rtcp_pkg::RST_BYTE;
            mask_reg <= 3'h0;
            flags_reg <= 3'h0;
            cnt_reg <= rtcp_pkg::RST_CNT;
            per_reg <= rtcp_pkg::RST_PER;
            cmp_reg <= rtcp_pkg::RST_CMP;
            stage_reg[0] <= rtcp_pkg::RST_CNT;
            stage_reg[1] <= rtcp_pkg::RST_PER;
            stage_reg[2] <= rtcp_pkg::RST_CMP;
            for (int i = 0; i < 3; i++)
                pend_reg[i] <= 2'h0;
            tap_reg <= '0;
            osc_prev_reg <= 1'b0;
            src_prev_reg <= 1'b0;
            pre_reg <= 17'h00000;
            ppm_reg <= '0;
            corr_reg <= 7'h00;
            pitc_reg <= 15'h0000;
        end else begin
            bus_reg <= bus_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            dbg_reg <= dbg_next;
            frequency_calibration_reg <= frequency_calibration_next;
            sel_reg <= sel_next;
            pit_reg <= pit_next;
            mask_reg <= mask_next;
            flags_reg <= flags_next;
            cnt_reg <= cnt_next;
            per_reg <= per_next;
            cmp_reg <= cmp_next;
            stage_reg <= stage_next;
            pend_reg <= pend_next;
            tap_reg <= tap_next;
            osc_prev_reg <= osc_prev_next;
            src_prev_reg <= src_prev_next;
            pre_reg <= pre_next;
            ppm_reg <= ppm_next;
            corr_reg <= corr_next;
            pitc_reg <= pitc_next;
        end
    end

    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in)
        && bus_reg != rtcp_pkg::BUS_ACK;
    assign irq_out = |(flags_reg & mask_reg);
endmodule : rtcp_core
`default_nettype wire

/* design/rtcp_pkg.sv */
// Constants for the real-time counter block
package rtcp_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_CTRL = 5'h00;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_INTMASK = 5'h02;
    localparam logic [4:0] IDX_INTFLAGS = 5'h03;
    localparam logic [4:0] IDX_DBG = 5'h05;
    localparam logic [4:0] IDX_FREQUENCY_CALIBRATION = 5'h06;
    localparam logic [4:0] IDX_CLOCK_SOURCE_SELECT = 5'h07;
    localparam logic [4:0] IDX_CNT_L = 5'h08;
    localparam logic [4:0] IDX_CNT_H = 5'h09;
    localparam logic [4:0] IDX_PER_L = 5'h0a;
    localparam logic [4:0] IDX_PER_H = 5'h0b;
    localparam logic [4:0] IDX_CMP_L = 5'h0c;
    localparam logic [4:0] IDX_CMP_H = 5'h0d;
    localparam logic [4:0] IDX_PIT = 5'h10;
    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] RST_PER = 16'hffff;
    localparam logic [15:0] RST_CMP = 16'h0000;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CORR_BIT = 2;
    localparam int CTRL_PRE_LSB = 3;
    localparam int FREQUENCY_CALIBRATION_SIGN_BIT = 7;
    localparam int PIT_EN_BIT = 0;
    localparam int PIT_CODE_LSB = 3;
    localparam int FLAG_WRAP = 0;
    localparam int FLAG_MATCH = 1;
    localparam int FLAG_PIT = 2;
    localparam int BUSY_LSB = 1;
    // ------------------------------------------------------------
    // Source codes, sync indices and timing
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_INT32K = 2'h0;
    localparam logic [1:0] SRC_INT1K = 2'h1;
    localparam logic [1:0] SRC_XTAL = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    localparam int SY_CNT = 0;
    localparam int SY_PER = 1;
    localparam int SY_CMP = 2;
    localparam logic [1:0] SYNC_LAT = 2'h2;
    localparam logic [3:0] PIT_OFF = 4'h0;
    localparam logic [3:0] PIT_RSVD = 4'hf;
    localparam int unsigned PPM_INTERVAL = 1000000;
    localparam int unsigned TAP_DIV = 32;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } rtcp_bus_t;
endpackage : rtcp_pkg

/* bench/rtcp_core_sva.sv */
// Checker for the real-time counter bus and read-back ports
`timescale 1ns/1ps
`default_nettype none
module rtcp_core_sva #(
    parameter int unsigned PPM_INTERVAL = 100,
    parameter int unsigned TAP_DIV = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic irq_out
);
    // ------------------------------------------------------------
    // Bus timing and register shapes
    // ------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_rd_at(logic [4:0] a);
        avs_read_in && !avs_waitrequest_out && avs_address_in == a;
    endsequence
    a_one_wait: assert property (s_req |=> !avs_waitrequest_out)
        else $error("request not answered after one wait");
    a_idle_no_wait: assert property
        (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("waitrequest high with no request");
    a_upper_zero: assert property
        (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // Read data must stand until the next read loads it
    a_rdata_hold: assert property (!(avs_read_in && avs_waitrequest_out)
        |=> $stable(avs_readdata_out))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property
        (s_rd_at(5'h04) |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_source_bits: assert property
        (s_rd_at(5'h07) |-> avs_readdata_out[7:2] == 6'h00)
        else $error("source register spare bits set");
    a_tick_ctrl_bits: assert property (s_rd_at(5'h10) |->
        avs_readdata_out[7] == 1'b0 && avs_readdata_out[2:1] == 2'h0)
        else $error("periodic control spare bits set");
    a_halt_bits: assert property
        (s_rd_at(5'h05) |-> avs_readdata_out[7:1] == 7'h00)
        else $error("debug register spare bits set");
    a_status_bits: assert property
        (s_rd_at(5'h01) |-> avs_readdata_out[7:4] == 4'h0)
        else $error("status spare bits set");
    a_irq_after_reset: assert property ($fell(rst_in) |-> !irq_out)
        else $error("interrupt high right after reset");
endmodule : rtcp_core_sva
bind rtcp_core rtcp_core_sva #(.PPM_INTERVAL(PPM_INTERVAL), .TAP_DIV(TAP_DIV))
    u_chk (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .irq_out(irq_out),
    .avs_waitrequest_out(avs_waitrequest_out));
`default_nettype wire

/* bench/rtcp_core_tb_top.sv */
// Self-checking bench for the real-time counter
`timescale 1ns/1ps
`default_nettype none
module rtcp_core_tb_top;
    localparam int TAP = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic [2:0] osc = 3'h0;
    logic halted = 1'b0;
    logic irq;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] v;
    logic [4:0] t_addr [11] = '{5'h05, 5'h06, 5'h07, 5'h10, 5'h04, 5'h08,
        5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
    logic [7:0] t_rst [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
    logic [7:0] t_wr [5] = '{8'h01, 8'hff, 8'h03, 8'h79, 8'h00};
    logic [15:0] s_val [3] = '{16'h0001, 16'h0003, 16'h0002};
    always #50 clk_in = ~clk_in;
    rtcp_core #(.PPM_INTERVAL(100), .TAP_DIV(TAP)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'h1), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_req), .internal_32k_oscillator_in(osc[0]),
        .crystal_32k_source_in(osc[1]), .external_pin_source_in(osc[2]),
        .cpu_halted_in(halted), .irq_out(irq));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string name, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Request held until waitrequest is seen low; no latency assumed
    task automatic bus(input logic dir, input logic [4:0] a,
        input logic [7:0] d);
        int k;
        @(posedge clk_in);
        addr <= a;
        wdata <= {24'h0, d};
        rd <= ~dir;
        wr <= dir;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (wait_req !== 1'b0 && k < 20);
        if (wait_req !== 1'b0) begin
            err_total++;
            report_and_stop();
        end
        v = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // Pulses the pin source until the interrupt rises, bounded
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            pulse(2, 1);
            n++;
        end
        if (irq !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
    endtask : wait_irq
    // Slow source edges, each wide enough to be seen at the bus clock
    task automatic pulse(input int line, input int n);
        repeat (n) begin
            @(posedge clk_in);
            osc[line] <= 1'b1;
            repeat (3) @(posedge clk_in);
            osc[line] <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        @(negedge clk_in);
    endtask : pulse
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, t_addr[i], 8'h00);
            chk("reset value", {8'h00, v}, {8'h00, t_rst[i]});
            if (i < 5) begin
                bus(1'b1, t_addr[i], 8'hff);
                bus(1'b0, t_addr[i], 8'h00);
                chk("read back", {8'h00, v}, {8'h00, t_wr[i]});
                bus(1'b1, t_addr[i], 8'h00);
            end
        end
        $display("test registers done");
    endtask : t_regs
    task automatic t_sync;
        logic [4:0] a;
        logic [7:0] lo;
        bus(1'b1, 5'h07, 8'h03);
        for (int k = 0; k < 3; k++) begin
            a = 5'h08 + 5'(2 * k);
            bus(1'b1, a, s_val[k][7:0]);
            bus(1'b1, a + 5'h01, s_val[k][15:8]);
            for (int p = 0; p < 3; p++) begin
                bus(1'b0, 5'h01, 8'h00);
                chk("pending", {15'h0, v[k + 1]}, {15'h0, p < 2});
                if (p < 2) pulse(2, 1);
            end
            bus(1'b0, a, 8'h00);
            lo = v;
            bus(1'b0, a + 5'h01, 8'h00);
            chk("synced value", {v, lo}, s_val[k]);
        end
        $display("test sync done");
    endtask : t_sync
    task automatic t_sources;
        logic [7:0] c;
        bus(1'b1, 5'h00, 8'h01);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 5'h07, 8'(s));
            bus(1'b0, 5'h08, 8'h00);
            c = v;
            pulse(s == 3 ? 2 : (s == 2 ? 1 : 0), s == 1 ? TAP : 1);
            bus(1'b0, 5'h08, 8'h00);
            c = (c == 8'h03) ? 8'h00 : c + 8'h01;
            chk("count step", {8'h00, v}, {8'h00, c});
        end
        bus(1'b1, 5'h00, 8'h00);
        $display("test sources done");
    endtask : t_sources
    task automatic t_flags;
        bus(1'b1, 5'h08, 8'h01);
        pulse(2, 2);
        bus(1'b0, 5'h03, 8'h00);
        bus(1'b1, 5'h02, 8'h03);
        bus(1'b1, 5'h00, 8'h01);
        pulse(2, 1);
        chk("irq on match", {15'h0, irq}, 16'h0001);
        bus(1'b0, 5'h03, 8'h00);
        chk("match flag", {8'h00, v}, 16'h0002);
        repeat (2) @(negedge clk_in);
        chk("irq after read", {15'h0, irq}, 16'h0000);
        pulse(2, 2);
        bus(1'b0, 5'h03, 8'h00);
        chk("wrap flag", {8'h00, v}, 16'h0001);
        pulse(2, 2);
        bus(1'b1, 5'h03, 8'h02);
        bus(1'b0, 5'h03, 8'h00);
        chk("flag after clear", {8'h00, v}, 16'h0000);
        halted <= 1'b1;
        pulse(2, 2);
        bus(1'b0, 5'h08, 8'h00);
        chk("count in halt", {8'h00, v}, 16'h0002);
        bus(1'b1, 5'h05, 8'h01);
        pulse(2, 1);
        bus(1'b0, 5'h08, 8'h00);
        chk("count with run bit", {8'h00, v}, 16'h0003);
        halted <= 1'b0;
        bus(1'b1, 5'h05, 8'h00);
        bus(1'b1, 5'h00, 8'h00);
        $display("test flags done");
    endtask : t_flags
    task automatic t_pit;
        int n;
        bus(1'b1, 5'h02, 8'h04);
        // Off and reserved codes must stay silent
        for (int c = 0; c < 16; c += 15) begin
            bus(1'b1, 5'h10, 8'((c << 3) | 1));
            bus(1'b0, 5'h03, 8'h00);
            pulse(2, 8);
            chk("no periodic tick", {15'h0, irq}, 16'h0000);
        end
        for (int c = 1; c < 4; c++) begin
            bus(1'b1, 5'h10, 8'((c << 3) | 1));
            wait_irq(n);
            bus(1'b0, 5'h03, 8'h00);
            repeat (2) @(negedge clk_in);
            wait_irq(n);
            chk("periodic spacing", 16'(n), 16'(1 << (c + 1)));
        end
        bus(1'b1, 5'h02, 8'h00);
        repeat (2) @(negedge clk_in);
        chk("irq masked", {15'h0, irq}, 16'h0000);
        bus(1'b0, 5'h03, 8'h00);
        chk("flag kept when masked", {8'h00, v}, 16'h0004);
        $display("test periodic done");
    endtask : t_pit
    // Mid-run reset starts a fresh correction window at a known point
    task automatic t_frequency_calibration;
        logic [7:0] cal [3] = '{8'h84, 8'h04, 8'h84};
        logic [7:0] ctl [3] = '{8'h0d, 8'h0d, 8'h09};
        logic [7:0] cnt_exp [3] = '{8'h39, 8'h35, 8'h37};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            rst_in <= 1'b1;
            repeat (2) @(posedge clk_in);
            rst_in <= 1'b0;
            bus(1'b1, 5'h07, 8'h03);
            bus(1'b1, 5'h06, cal[i]);
            bus(1'b1, 5'h00, ctl[i]);
            pulse(2, 110);
            bus(1'b0, 5'h08, 8'h00);
            chk("corrected count", {8'h00, v}, {8'h00, cnt_exp[i]});
        end
        $display("test calibration done");
    endtask : t_frequency_calibration
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_sync();
        t_sources();
        t_flags();
        t_pit();
        t_frequency_calibration();
        report_and_stop();
    end
endmodule : rtcp_core_tb_top
`default_nettype wire
